// [rtl/tmc_pkg.sv]
// constants, register map and carrier types for the timer/counter unit
// Functional notes
// - timer one counts when run set and, if gated, gate input one active
// - timer zero counts when run set and, if gated, gate input zero active
// - timer one counter select: count falling edges of its count pin
// - timer zero counter select: count falling edges of its count pin
// - timer one modes: 13-bit, 16-bit, 8-bit reload, inactive
// - timer zero modes: 13-bit, 16-bit, 8-bit reload, two 8-bit counters
// - timer one clock select: prescaled or system clock, ignored in counter mode
// - timer zero clock select: prescaled or system clock, ignored in counter mode
// - prescale field: system clock /12, /4, /48, or external clock /8
// - external clock /8 is synchronised before use as a count enable
// - fourth timer byte clock selects: system clock or external-clock-bit choice
// - third timer low select picks whole timer clock, or low byte in split
// - third timer high select used only in split mode
// - third timer external bit: system clock /12 or external clock /8
// - third timer 16-bit: overflow reloads counter and sets high flag
// - 16-bit interrupt on overflow, plus low-byte wraps when low enable set
// - split mode: two 8-bit counters, each reloads from its own byte
// - split mode: run bit gates only high counter, low always counts
// - split mode: each byte wrap sets its own overflow flag
// - split mode interrupt on high wraps, low wraps when low enable set
// - hardware never clears third timer flags; software clears them
// - timer zero low and high bytes form the count, both read/write
// - 13-bit mode uses high byte plus five low bits, sets overflow flag
// - 8-bit reload: low counts, reloads from high on overflow, flag set
// - timer zero split: high byte counts on timer clock, run and flag of one
// - third timer low flag set on every low wrap in any mode
package tmc_pkg;

   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
   localparam logic [7:0] ADDR_MODE_SELECT = 8'h89;
   localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
   localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
   localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
   localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
   localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h8e;
   localparam logic [7:0] ADDR_FOURTH_CONTROL = 8'h91;
   localparam logic [7:0] ADDR_THIRD_CONTROL = 8'hc8;
   localparam logic [7:0] ADDR_THIRD_RELOAD_LOW = 8'hca;
   localparam logic [7:0] ADDR_THIRD_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] ADDR_THIRD_LOW = 8'hcc;
   localparam logic [7:0] ADDR_THIRD_HIGH = 8'hcd;
   localparam logic [7:0] ADDR_GATE_CONFIG = 8'he4;

   localparam logic [7:0] RESET_VALUE = 8'h00;

   // timer control bits
   localparam int TC_T1_FLAG = 7;
   localparam int TC_T1_RUN = 6;
   localparam int TC_T0_FLAG = 5;
   localparam int TC_T0_RUN = 4;
   // mode select bits
   localparam int MS_T1_GATE = 7;
   localparam int MS_T1_COUNTER = 6;
   localparam int MS_T1_MODE = 4;
   localparam int MS_T0_GATE = 3;
   localparam int MS_T0_COUNTER = 2;
   localparam int MS_T0_MODE = 0;
   // clock select bits
   localparam int CS_T3_HIGH = 7;
   localparam int CS_T3_LOW = 6;
   localparam int CS_T2_HIGH = 5;
   localparam int CS_T2_LOW = 4;
   localparam int CS_T1_SYS = 3;
   localparam int CS_T0_SYS = 2;
   localparam int CS_PRESCALE = 0;
   // third / fourth timer control bits
   localparam int TT_HIGH_FLAG = 7;
   localparam int TT_LOW_FLAG = 6;
   localparam int TT_LOW_IRQ_EN = 5;
   localparam int TT_CAPTURE_EN = 4;
   localparam int TT_SPLIT = 3;
   localparam int TT_RUN = 2;
   localparam int TT_EXT_CLOCK = 0;
   // gate config bits
   localparam int GC_ZERO_POLARITY = 0;
   localparam int GC_ONE_POLARITY = 1;

   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_8RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;

   localparam logic [1:0] PRE_DIV12 = 2'h0;
   localparam logic [1:0] PRE_DIV4 = 2'h1;
   localparam logic [1:0] PRE_DIV48 = 2'h2;

   localparam int NUM_DIVS = 3;
   localparam logic [5:0] DIV_12 = 6'h0c;
   localparam logic [5:0] DIV_4 = 6'h04;
   localparam logic [5:0] DIV_48 = 6'h30;
   localparam logic [2:0] EXT_DIV_LAST = 3'h7;
   localparam logic [12:0] MAX_13 = 13'h1fff;
   localparam logic [7:0] MAX_8 = 8'hff;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tmc_bus_req_s;

   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
      logic ovf;
   } tmc_step_s;

endpackage

// [rtl/tmc_timers.sv]
// timer/counter unit: two general timers, third auto-reload timer, fourth timer clocks
//
// The address-and-strobe port was chosen for this implementation.
module tmc_timers (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire tmc_pkg::tmc_bus_req_s bus_req,
   output logic [7:0] rd_data,
   input wire logic timer_zero_count_pin,
   input wire logic timer_one_count_pin,
   input wire logic gate_input_zero,
   input wire logic gate_input_one,
   input wire logic ext_osc,
   output logic timer_zero_overflow_flag,
   output logic timer_one_overflow_flag,
   output logic third_timer_irq_request,
   output logic fourth_timer_low_tick,
   output logic fourth_timer_high_tick
);

   // one count step of a general timer, or the split low byte
   function automatic tmc_pkg::tmc_step_s tmc_step(input logic [1:0] mode,
         input logic [7:0] low, input logic [7:0] high);
      tmc_pkg::tmc_step_s s;
      logic [12:0] c13;
      s = '{low: low, high: high, ovf: 1'b0};
      c13 = {high, low[4:0]};
      case (mode)
         tmc_pkg::MODE_13BIT: begin
            c13 = c13 + 13'h0001;
            s.high = c13[12:5];
            s.low = {low[7:5], c13[4:0]};
            s.ovf = ({high, low[4:0]} == tmc_pkg::MAX_13);
         end
         tmc_pkg::MODE_16BIT: begin
            {s.high, s.low} = {high, low} + 16'h0001;
            s.ovf = ({high, low} == 16'hffff);
         end
         tmc_pkg::MODE_8RELOAD: begin
            s.ovf = (low == tmc_pkg::MAX_8);
            s.low = s.ovf ? high : low + 8'h01;
         end
         default: begin
            s.ovf = (low == tmc_pkg::MAX_8);
            s.low = low + 8'h01;
         end
      endcase
      return s;
   endfunction

   // clock choice for third and fourth timer bytes
   function automatic logic tmc_tick_sel(input logic sys_sel, input logic ext_bit,
         input logic div12, input logic ext8);
      return sys_sel ? 1'b1 : (ext_bit ? ext8 : div12);
   endfunction

   logic [7:0] control_reg, mode_reg, clock_reg, gate_cfg_reg;
   logic [7:0] t0_low_reg, t0_high_reg, t1_low_reg, t1_high_reg;
   logic [7:0] third_ctl_reg, rl_low_reg, rl_high_reg, t2_low_reg, t2_high_reg;
   logic [7:0] fourth_ctl_reg, rd_data_reg, rd_data_next;

   // input synchronisers: ext_osc, count pin zero, count pin one
   logic [2:0] pin_raw, sync1_reg, sync2_reg, prev_reg;
   logic [2:0] pin_fall, pin_rise;
   assign pin_raw = {timer_one_count_pin, timer_zero_count_pin, ext_osc};

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         prev_reg <= 3'h0;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end
   assign pin_fall = prev_reg & ~sync2_reg;
   assign pin_rise = ~prev_reg & sync2_reg;

   // external clock divided by 8, counted on synchronised rising edges
   logic [2:0] ext_cnt_reg;
   logic ext8_tick;
   assign ext8_tick = pin_rise[0] && (ext_cnt_reg == tmc_pkg::EXT_DIV_LAST);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ext_cnt_reg <= 3'h0;
      end else if (pin_rise[0]) begin
         ext_cnt_reg <= ext_cnt_reg + 3'h1;
      end
   end

   // system clock dividers: one-cycle enables, no derived clocks
   localparam logic [5:0] DIVS [tmc_pkg::NUM_DIVS] = '{tmc_pkg::DIV_12, tmc_pkg::DIV_4,
      tmc_pkg::DIV_48};
   logic [tmc_pkg::NUM_DIVS-1:0] div_tick;
   genvar gi;
   generate
      for (gi = 0; gi < tmc_pkg::NUM_DIVS; gi++) begin : g_div
         logic [5:0] cnt_reg;
         assign div_tick[gi] = (cnt_reg == DIVS[gi] - 6'h01);
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               cnt_reg <= 6'h00;
            end else begin
               cnt_reg <= div_tick[gi] ? 6'h00 : cnt_reg + 6'h01;
            end
         end
      end
   endgenerate

   logic presc_tick;
   assign presc_tick = (clock_reg[1:0] == tmc_pkg::PRE_DIV12) ? div_tick[0] :
                       (clock_reg[1:0] == tmc_pkg::PRE_DIV4) ? div_tick[1] :
                       (clock_reg[1:0] == tmc_pkg::PRE_DIV48) ? div_tick[2] : ext8_tick;

   // register decode
   logic wr_ctl, wr_mode, wr_t0l, wr_t1l, wr_t0h, wr_t1h, wr_clk, wr_fourth;
   logic wr_third, wr_rll, wr_rlh, wr_t2l, wr_t2h, wr_gcfg;
   assign wr_ctl = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_TIMER_CONTROL);
   assign wr_mode = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_MODE_SELECT);
   assign wr_t0l = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_T0_LOW);
   assign wr_t1l = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_T1_LOW);
   assign wr_t0h = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_T0_HIGH);
   assign wr_t1h = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_T1_HIGH);
   assign wr_clk = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_CLOCK_SELECT);
   assign wr_fourth = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_FOURTH_CONTROL);
   assign wr_third = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_THIRD_CONTROL);
   assign wr_rll = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_THIRD_RELOAD_LOW);
   assign wr_rlh = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_THIRD_RELOAD_HIGH);
   assign wr_t2l = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_THIRD_LOW);
   assign wr_t2h = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_THIRD_HIGH);
   assign wr_gcfg = bus_req.wr && (bus_req.addr == tmc_pkg::ADDR_GATE_CONFIG);

   // timer zero
   logic [1:0] t0_mode, t1_mode;
   logic t0_split, t0_gate_ok, t0_src, t0_en, t0h_en;
   tmc_pkg::tmc_step_s t0_step, t1_step;
   assign t0_mode = mode_reg[tmc_pkg::MS_T0_MODE +: 2];
   assign t1_mode = mode_reg[tmc_pkg::MS_T1_MODE +: 2];
   assign t0_split = (t0_mode == tmc_pkg::MODE_SPLIT);
   assign t0_gate_ok = !mode_reg[tmc_pkg::MS_T0_GATE] ||
                       (gate_input_zero == gate_cfg_reg[tmc_pkg::GC_ZERO_POLARITY]);
   assign t0_src = mode_reg[tmc_pkg::MS_T0_COUNTER] ? pin_fall[1] :
                   (clock_reg[tmc_pkg::CS_T0_SYS] ? 1'b1 : presc_tick);
   assign t0_en = control_reg[tmc_pkg::TC_T0_RUN] && t0_gate_ok && t0_src;
   // split high byte borrows timer one's run bit and only a timer clock
   assign t0h_en = t0_split && control_reg[tmc_pkg::TC_T1_RUN] &&
                   (clock_reg[tmc_pkg::CS_T0_SYS] ? 1'b1 : presc_tick);
   assign t0_step = tmc_step(t0_mode, t0_low_reg, t0_high_reg);

   // timer one; in split of timer zero it keeps counting but loses pin and flag
   logic t1_gate_ok, t1_src, t1_en;
   assign t1_gate_ok = !mode_reg[tmc_pkg::MS_T1_GATE] ||
                       (gate_input_one == gate_cfg_reg[tmc_pkg::GC_ONE_POLARITY]);
   assign t1_src = (mode_reg[tmc_pkg::MS_T1_COUNTER] && !t0_split) ? pin_fall[2] :
                   (clock_reg[tmc_pkg::CS_T1_SYS] ? 1'b1 : presc_tick);
   assign t1_en = (t1_mode != tmc_pkg::MODE_SPLIT) && t1_src &&
                  (t0_split || (control_reg[tmc_pkg::TC_T1_RUN] && t1_gate_ok));
   assign t1_step = tmc_step(t1_mode, t1_low_reg, t1_high_reg);

   logic t0_ovf, t1_ovf;
   logic [7:0] t0_low_next, t0_high_next, t1_low_next, t1_high_next, control_next;
   assign t0_ovf = t0_en && t0_step.ovf;
   assign t1_ovf = t0_split ? (t0h_en && (t0_high_reg == tmc_pkg::MAX_8)) :
                   (t1_en && t1_step.ovf);
   assign t0_low_next = wr_t0l ? bus_req.wdata : (t0_en ? t0_step.low : t0_low_reg);
   assign t0_high_next = wr_t0h ? bus_req.wdata :
                         t0_split ? (t0h_en ? t0_high_reg + 8'h01 : t0_high_reg) :
                         (t0_en ? t0_step.high : t0_high_reg);
   assign t1_low_next = wr_t1l ? bus_req.wdata : (t1_en ? t1_step.low : t1_low_reg);
   assign t1_high_next = wr_t1h ? bus_req.wdata : (t1_en ? t1_step.high : t1_high_reg);
   // hardware set wins over a software clear in the same cycle
   always_comb begin
      control_next = wr_ctl ? bus_req.wdata : control_reg;
      control_next[3:0] = 4'h0;
      control_next[tmc_pkg::TC_T0_FLAG] = control_next[tmc_pkg::TC_T0_FLAG] | t0_ovf;
      control_next[tmc_pkg::TC_T1_FLAG] = control_next[tmc_pkg::TC_T1_FLAG] | t1_ovf;
   end

   // third timer
   logic t2_split, t2_reload_ok, t2_lo_tick, t2_hi_tick, t2l_en, t2h_en, t2l_wrap, t2h_wrap;
   logic t2l_reload;
   logic [7:0] t2_low_next, t2_high_next, third_next;
   assign t2_split = third_ctl_reg[tmc_pkg::TT_SPLIT];
   // capture is not built here; with capture enabled the counter free-runs without reload
   assign t2_reload_ok = !third_ctl_reg[tmc_pkg::TT_CAPTURE_EN];
   assign t2_lo_tick = tmc_tick_sel(clock_reg[tmc_pkg::CS_T2_LOW],
                                    third_ctl_reg[tmc_pkg::TT_EXT_CLOCK],
                                    div_tick[0], ext8_tick);
   assign t2_hi_tick = tmc_tick_sel(clock_reg[tmc_pkg::CS_T2_HIGH],
                                    third_ctl_reg[tmc_pkg::TT_EXT_CLOCK],
                                    div_tick[0], ext8_tick);
   assign t2l_en = t2_split ? t2_lo_tick : (third_ctl_reg[tmc_pkg::TT_RUN] && t2_lo_tick);
   assign t2h_en = t2_split ? (third_ctl_reg[tmc_pkg::TT_RUN] && t2_hi_tick) :
                   (t2l_en && (t2_low_reg == tmc_pkg::MAX_8));
   assign t2l_wrap = t2l_en && (t2_low_reg == tmc_pkg::MAX_8);
   assign t2h_wrap = t2h_en && (t2_high_reg == tmc_pkg::MAX_8);
   assign t2l_reload = t2_reload_ok && (t2_split ? t2l_wrap : t2h_wrap);
   assign t2_low_next = wr_t2l ? bus_req.wdata :
                        t2l_reload ? rl_low_reg :
                        (t2l_en ? t2_low_reg + 8'h01 : t2_low_reg);
   assign t2_high_next = wr_t2h ? bus_req.wdata :
                         (t2_reload_ok && t2h_wrap) ? rl_high_reg :
                         (t2h_en ? t2_high_reg + 8'h01 : t2_high_reg);
   // hardware only sets flags; software clears them
   always_comb begin
      third_next = wr_third ? bus_req.wdata : third_ctl_reg;
      third_next[tmc_pkg::TT_HIGH_FLAG] = third_next[tmc_pkg::TT_HIGH_FLAG] | t2h_wrap;
      third_next[tmc_pkg::TT_LOW_FLAG] = third_next[tmc_pkg::TT_LOW_FLAG] | t2l_wrap;
   end
   assign third_timer_irq_request = third_ctl_reg[tmc_pkg::TT_HIGH_FLAG] ||
      (third_ctl_reg[tmc_pkg::TT_LOW_FLAG] && third_ctl_reg[tmc_pkg::TT_LOW_IRQ_EN]);

   // fourth timer: only its byte clock enables are produced here
   logic t3_lo_sel;
   assign t3_lo_sel = tmc_tick_sel(clock_reg[tmc_pkg::CS_T3_LOW],
                                   fourth_ctl_reg[tmc_pkg::TT_EXT_CLOCK],
                                   div_tick[0], ext8_tick);
   assign fourth_timer_low_tick = t3_lo_sel;
   assign fourth_timer_high_tick = fourth_ctl_reg[tmc_pkg::TT_SPLIT] ?
      tmc_tick_sel(clock_reg[tmc_pkg::CS_T3_HIGH], fourth_ctl_reg[tmc_pkg::TT_EXT_CLOCK],
                   div_tick[0], ext8_tick) : t3_lo_sel;

   // read mux; unmapped addresses read zero
   always_comb begin
      case (bus_req.addr)
         tmc_pkg::ADDR_TIMER_CONTROL: rd_data_next = control_reg;
         tmc_pkg::ADDR_MODE_SELECT: rd_data_next = mode_reg;
         tmc_pkg::ADDR_T0_LOW: rd_data_next = t0_low_reg;
         tmc_pkg::ADDR_T1_LOW: rd_data_next = t1_low_reg;
         tmc_pkg::ADDR_T0_HIGH: rd_data_next = t0_high_reg;
         tmc_pkg::ADDR_T1_HIGH: rd_data_next = t1_high_reg;
         tmc_pkg::ADDR_CLOCK_SELECT: rd_data_next = clock_reg;
         tmc_pkg::ADDR_FOURTH_CONTROL: rd_data_next = fourth_ctl_reg;
         tmc_pkg::ADDR_THIRD_CONTROL: rd_data_next = third_ctl_reg;
         tmc_pkg::ADDR_THIRD_RELOAD_LOW: rd_data_next = rl_low_reg;
         tmc_pkg::ADDR_THIRD_RELOAD_HIGH: rd_data_next = rl_high_reg;
         tmc_pkg::ADDR_THIRD_LOW: rd_data_next = t2_low_reg;
         tmc_pkg::ADDR_THIRD_HIGH: rd_data_next = t2_high_reg;
         tmc_pkg::ADDR_GATE_CONFIG: rd_data_next = {6'h00, gate_cfg_reg[1:0]};
         default: rd_data_next = 8'h00;
      endcase
      if (!bus_req.rd) begin
         rd_data_next = 8'h00;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         control_reg <= tmc_pkg::RESET_VALUE;
         mode_reg <= tmc_pkg::RESET_VALUE;
         clock_reg <= tmc_pkg::RESET_VALUE;
         gate_cfg_reg <= tmc_pkg::RESET_VALUE;
         t0_low_reg <= tmc_pkg::RESET_VALUE;
         t0_high_reg <= tmc_pkg::RESET_VALUE;
         t1_low_reg <= tmc_pkg::RESET_VALUE;
         t1_high_reg <= tmc_pkg::RESET_VALUE;
         third_ctl_reg <= tmc_pkg::RESET_VALUE;
         rl_low_reg <= tmc_pkg::RESET_VALUE;
         rl_high_reg <= tmc_pkg::RESET_VALUE;
         t2_low_reg <= tmc_pkg::RESET_VALUE;
         t2_high_reg <= tmc_pkg::RESET_VALUE;
         fourth_ctl_reg <= tmc_pkg::RESET_VALUE;
         rd_data_reg <= tmc_pkg::RESET_VALUE;
      end else begin
         control_reg <= control_next;
         mode_reg <= wr_mode ? bus_req.wdata : mode_reg;
         clock_reg <= wr_clk ? bus_req.wdata : clock_reg;
         gate_cfg_reg <= wr_gcfg ? {6'h00, bus_req.wdata[1:0]} : gate_cfg_reg;
         t0_low_reg <= t0_low_next;
         t0_high_reg <= t0_high_next;
         t1_low_reg <= t1_low_next;
         t1_high_reg <= t1_high_next;
         third_ctl_reg <= third_next;
         rl_low_reg <= wr_rll ? bus_req.wdata : rl_low_reg;
         rl_high_reg <= wr_rlh ? bus_req.wdata : rl_high_reg;
         t2_low_reg <= t2_low_next;
         t2_high_reg <= t2_high_next;
         fourth_ctl_reg <= wr_fourth ? bus_req.wdata : fourth_ctl_reg;
         rd_data_reg <= rd_data_next;
      end
   end

   assign rd_data = rd_data_reg;
   assign timer_zero_overflow_flag = control_reg[tmc_pkg::TC_T0_FLAG];
   assign timer_one_overflow_flag = control_reg[tmc_pkg::TC_T1_FLAG];

endmodule

// [tb/testbench.sv]
// self-checking testbench for the timer/counter unit
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
   $display("MISMATCH %s exp %h got %h", what, exp, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, sys_rst, gate_input_zero, gate_input_one, osc_on, go;
   logic t0_pin, t1_pin, ext_osc, flag0, flag1, irq, tick_lo, tick_hi;
   tmc_pkg::tmc_bus_req_s bus_req;
   logic [7:0] rd_data;
   int n_errors = 0, n_compared = 0;
   tmc_timers i_tmc_timers (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
      .rd_data(rd_data), .timer_zero_count_pin(t0_pin), .timer_one_count_pin(t1_pin),
      .gate_input_zero(gate_input_zero), .gate_input_one(gate_input_one), .ext_osc(ext_osc),
      .timer_zero_overflow_flag(flag0), .timer_one_overflow_flag(flag1),
      .third_timer_irq_request(irq), .fourth_timer_low_tick(tick_lo),
      .fourth_timer_high_tick(tick_hi));
   tmc_pins_model i_tmc_pins_model (.sys_clk(sys_clk), .osc_on(osc_on), .go(go),
      .n_falls(8'h05), .timer_zero_count_pin(t0_pin), .timer_one_count_pin(t1_pin),
      .ext_osc(ext_osc));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask
   // {address, data} write list
   task automatic wrs(input logic [15:0] s [$]);
      foreach (s[i]) wr(s[i][15:8], s[i][7:0]);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      `CHK($sformatf("reg %h", a), e, d)
   endtask
   // latency-tolerant count window
   task automatic rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
      logic [7:0] d;
      rd(a, d);
      `CHK($sformatf("range reg %h", a), 1'b1, (d >= lo && d <= hi))
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      complete_run();
   end
   initial begin
      bus_req = '0;
      gate_input_zero = 1'b0;
      gate_input_one = 1'b0;
      osc_on = 1'b0;
      go = 1'b0;
      sys_rst = 1'b1;
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++) rchk(8'h88 + 8'(i), 8'h00);
      for (int i = 2; i < 6; i++) wr(8'h88 + 8'(i), 8'ha5 ^ 8'(i));
      for (int i = 2; i < 6; i++) rchk(8'h88 + 8'(i), 8'ha5 ^ 8'(i));
      wrs('{16'h8cff, 16'h8af0, 16'h8e04, 16'h8901, 16'h8810});
      wt(10);
      `CHK("t0 flag early", 1'b0, flag0)
      wt(10);
      `CHK("t0 flag 16 bit", 1'b1, flag0)
      wrs('{16'h8800, 16'h8900, 16'h8a1c, 16'h8cff, 16'h8810});
      wt(12);
      `CHK("t0 flag 13 bit", 1'b1, flag0)
      wrs('{16'h8800});
      rchk(8'h8c, 8'h00);
      wrs('{16'h8902, 16'h8c80, 16'h8afe, 16'h8810});
      wt(8);
      `CHK("t0 flag reload", 1'b1, flag0)
      wrs('{16'h8800});
      rchk(8'h8c, 8'h80);
      rng(8'h8a, 8'h80, 8'h8f);
      wrs('{16'h8903, 16'h8cfe, 16'h8840});
      wt(8);
      `CHK("t0 split high flag", 1'b1, flag1)
      wrs('{16'h8800, 16'h8930, 16'h8b00, 16'h8e08, 16'h8840});
      wt(10);
      wrs('{16'h8800});
      rchk(8'h8b, 8'h00);
      wrs('{16'h8910, 16'h8bf8, 16'h8dff, 16'h8840});
      wt(14);
      `CHK("t1 flag 16 bit", 1'b1, flag1)
      wrs('{16'h8800, 16'h8909, 16'he401, 16'h8a00, 16'h8c00, 16'h8e04, 16'h8810});
      wt(10);
      wrs('{16'h8800});
      rchk(8'h8a, 8'h00);
      gate_input_zero <= 1'b1;
      wrs('{16'h8810});
      wt(10);
      wrs('{16'h8800});
      rng(8'h8a, 8'h08, 8'h14);
      wrs('{16'h8990, 16'h8b00, 16'h8d00, 16'h8840});
      wt(24);
      wrs('{16'h8800});
      rng(8'h8b, 8'h01, 8'h03);
      wrs('{16'h8945, 16'h8a00, 16'h8b00, 16'h8c00, 16'h8850});
      go <= 1'b1;
      wt(1);
      go <= 1'b0;
      wt(60);
      wrs('{16'h8800});
      rchk(8'h8a, 8'h05);
      rchk(8'h8b, 8'h05);
      wrs('{16'h8901, 16'h8a00, 16'h8e01, 16'h8810});
      wt(40);
      wrs('{16'h8800});
      rng(8'h8a, 8'h09, 8'h0c);
      wrs('{16'hca34, 16'hcb12, 16'hccfe, 16'hcdff, 16'h8e10, 16'hc804});
      wt(6);
      rchk(8'hc8, 8'hc4);
      `CHK("irq 16 bit", 1'b1, irq)
      wrs('{16'hc800});
      wt(1);
      `CHK("irq cleared", 1'b0, irq)
      rchk(8'hcd, 8'h12);
      wrs('{16'hca55, 16'hccfe, 16'hcd77, 16'hc808});
      wt(6);
      rchk(8'hcd, 8'h77);
      rchk(8'hc8, 8'h48);
      `CHK("irq low masked", 1'b0, irq)
      wrs('{16'hc868});
      wt(1);
      `CHK("irq low enabled", 1'b1, irq)
      rng(8'hcc, 8'h55, 8'h7f);
      wrs('{16'hc800, 16'h8e40});
      wt(4);
      `CHK("low tick", 1'b1, tick_lo)
      wrs('{16'h9108, 16'h8ec0, 16'h8e03, 16'h9101, 16'h8a00, 16'h8810});
      osc_on <= 1'b1;
      wt(200);
      osc_on <= 1'b0;
      wt(2);
      rchk(8'h8a, 8'h04);
      complete_run();
   end
endmodule

// [tb/tmc_pins_model.sv]
// external count pins and oscillator source for the timer/counter unit
module tmc_pins_model (
   input wire logic sys_clk,
   input wire logic osc_on,
   input wire logic go,
   input wire logic [7:0] n_falls,
   output logic timer_zero_count_pin,
   output logic timer_one_count_pin,
   output logic ext_osc
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      timer_zero_count_pin = 1'b1;
      timer_one_count_pin = 1'b1;
      ext_osc = 1'b0;
   end
   // three-cycle phases so the synchroniser never misses an edge
   always begin
      @(posedge sys_clk);
      if (go) begin
         repeat (n_falls) begin
            repeat (3) @(posedge sys_clk);
            timer_zero_count_pin <= 1'b0;
            timer_one_count_pin <= 1'b0;
            repeat (3) @(posedge sys_clk);
            timer_zero_count_pin <= 1'b1;
            timer_one_count_pin <= 1'b1;
         end
      end
   end
   // low while off; three-cycle phases stay slower than half the clock
   always begin
      repeat (3) @(posedge sys_clk);
      ext_osc <= osc_on ? ~ext_osc : 1'b0;
   end
endmodule

// [tb/tmc_timers_sva.sv]
// port checker for the timer/counter unit
module tmc_timers_sva (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire tmc_pkg::tmc_bus_req_s bus_req,
   input wire logic [7:0] rd_data,
   input wire logic timer_zero_count_pin,
   input wire logic timer_one_count_pin,
   input wire logic gate_input_zero,
   input wire logic gate_input_one,
   input wire logic ext_osc,
   input wire logic timer_zero_overflow_flag,
   input wire logic timer_one_overflow_flag,
   input wire logic third_timer_irq_request,
   input wire logic fourth_timer_low_tick,
   input wire logic fourth_timer_high_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ms_reg, cs_reg, c4_reg;
   logic [5:0] gap_reg, m12_reg, mx_reg;
   logic div12, ext8;
   // register shadows; gaps saturate so idle spans stay legal
   assign div12 = !cs_reg[6] && !c4_reg[0];
   assign ext8 = !cs_reg[6] && c4_reg[0];
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ms_reg <= 8'h00;
         cs_reg <= 8'h00;
         c4_reg <= 8'h00;
         gap_reg <= 6'h00;
         m12_reg <= 6'h00;
         mx_reg <= 6'h00;
      end else begin
         if (bus_req.wr && bus_req.addr == 8'h89) ms_reg <= bus_req.wdata;
         if (bus_req.wr && bus_req.addr == 8'h8e) cs_reg <= bus_req.wdata;
         if (bus_req.wr && bus_req.addr == 8'h91) c4_reg <= bus_req.wdata;
         gap_reg <= fourth_timer_low_tick ? 6'h00 : gap_reg + {5'h00, gap_reg != 6'h3f};
         m12_reg <= div12 ? m12_reg + {5'h00, m12_reg != 6'h3f} : 6'h00;
         mx_reg <= ext8 ? mx_reg + {5'h00, mx_reg != 6'h3f} : 6'h00;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   AST_RD_IDLE: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
      else $error("stray read data");
   AST_RD_UNMAPPED: assert property (bus_req.rd && bus_req.addr == 8'h8f |=> rd_data == 8'h00)
      else $error("unmapped read");
   AST_RD_MODE: assert property (bus_req.rd && bus_req.addr == 8'h89 |=> rd_data == ms_reg)
      else $error("mode readback");
   AST_RD_CLOCK: assert property (bus_req.rd && bus_req.addr == 8'h8e ##1 1 |-> rd_data == $past(cs_reg))
      else $error("clock readback");
   AST_T0_FLAG_HOLD: assert property ($past(timer_zero_overflow_flag) && !$past(sys_rst)
      && !$past(bus_req.wr && bus_req.addr == 8'h88) |-> timer_zero_overflow_flag)
      else $error("t0 flag dropped");
   AST_T1_FLAG_HOLD: assert property ($fell(timer_one_overflow_flag) |-> $past(bus_req.wr)
      && $past(bus_req.addr) == 8'h88)
      else $error("t1 flag dropped");
   AST_IRQ_HOLD: assert property ($fell(third_timer_irq_request) |-> $past(bus_req.wr)
      && $past(bus_req.addr) == 8'hc8)
      else $error("irq dropped");
   AST_TICK_SYS: assert property (cs_reg[6] && $past(cs_reg[6]) |-> fourth_timer_low_tick)
      else $error("low tick missing");
   AST_TICK_HIGH: assert property ((cs_reg[7] && c4_reg[3])[*2] |-> fourth_timer_high_tick)
      else $error("high tick missing");
   AST_DIV12: assert property (fourth_timer_low_tick && m12_reg >= 6'd13 |-> gap_reg == 6'd11)
      else $error("div12 spacing");
   AST_EXT8: assert property (fourth_timer_low_tick && mx_reg >= 6'd60 |-> gap_reg >= 6'd31)
      else $error("ext8 too fast");
endmodule
bind tmc_timers tmc_timers_sva i_tmc_timers_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .bus_req(bus_req), .rd_data(rd_data), .timer_zero_count_pin(timer_zero_count_pin),
   .timer_one_count_pin(timer_one_count_pin), .gate_input_zero(gate_input_zero),
   .gate_input_one(gate_input_one), .ext_osc(ext_osc),
   .timer_zero_overflow_flag(timer_zero_overflow_flag),
   .timer_one_overflow_flag(timer_one_overflow_flag),
   .third_timer_irq_request(third_timer_irq_request),
   .fourth_timer_low_tick(fourth_timer_low_tick), .fourth_timer_high_tick(fourth_timer_high_tick));
